// ==== serial_ctrl_pkg.sv ====
`default_nettype none

package serial_ctrl_pkg;

  // ==========================================================
  // Widths
  localparam int NIB_W   = 4;
  localparam int PORT_W  = 8;
  localparam int PC_W    = 11;
  localparam int STACK_N = 3;

  // ==========================================================
  // Feature-enable bit positions
  localparam int FE_COUNTER = 0;
  localparam int FE_INT     = 1;
  localparam int FE_DRIVE   = 2;
  localparam int FE_SO      = 3;

  // ==========================================================
  // Reset values
  localparam logic [NIB_W-1:0]  FEATURE_RESET = 4'h0;
  localparam logic [PC_W-1:0]   PC_RESET      = 11'h000;
  localparam logic [NIB_W-1:0]  NIB_RESET     = 4'h0;
  localparam logic [PORT_W-1:0] PORT_RESET    = 8'h00;
  localparam logic              GATE_RESET    = 1'b1;

  // ==========================================================
  // Interrupt
  localparam logic [PC_W-1:0] INT_VECTOR   = 11'h0FF;
  localparam logic [1:0]      INT_LOW_MIN  = 2'h2;
  localparam logic [PC_W-1:0] PC_STEP      = 11'h001;

endpackage : serial_ctrl_pkg

`default_nettype wire

// ==== serial_ctrl.sv ====
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Counter mode: decrement on serial_in falls
// - Counter mode: clock out gate, out allow
// - Shift mode: shift left, serial_in in
// - Shift mode: clock out gate AND clock
// - Shift mode, allow set: MSB out
// - Shift mode, allow clear: output zero
// - Swap exchanges accumulator, carry to gate
// - Feature register loaded only by instruction
// - Taking interrupt clears interrupt allow
// - Port drives latch when allowed or during a host read
// - Interrupt needs allow, pulse, instruction done
// - Interrupt pushes next address, jumps 0FF
// - Three-entry return stack, push and pop
// - Program counter steps unless transfer given
// - Host mode turns inputs into strobes
// - Host write loads port into latch
// - Port levels always readable
// - Host mode: ready output handshake
// - Reset clears state, sets clock gate
// - Skip state saved on interrupt push, restored on pop
// - Host write clears ready output
// - No interrupt after transfer or load chain
module serial_ctrl
  import serial_ctrl_pkg::*;
(
  // Clocks and reset
  input  wire logic              clock,
  input  wire logic              reset,
  input  wire logic              link_clock,
  // Sequencer
  input  wire logic              instr_done,
  input  wire logic              instr_chain,
  input  wire logic              op_call,
  input  wire logic              op_ret,
  input  wire logic              op_jump,
  input  wire logic [PC_W-1:0]   jump_addr,
  input  wire logic              skip_pending,
  output logic                   skip_restore,
  input  wire logic              load_feature_enable,
  input  wire logic [NIB_W-1:0]  feature_value,
  input  wire logic              swap_accum_serial,
  input  wire logic [NIB_W-1:0]  accum_in,
  input  wire logic              carry_in,
  output logic      [NIB_W-1:0]  accum_out,
  input  wire logic              load_latch,
  input  wire logic [PORT_W-1:0] latch_value,
  input  wire logic              ready_set,
  output logic      [PORT_W-1:0] port_read_data,
  output logic      [PC_W-1:0]   program_counter,
  output logic                   interrupt_taken,
  // Serial pins
  input  wire logic              serial_in,
  output logic                   serial_out,
  output logic                   serial_clock_out,
  // General and host pins
  input  wire logic              input_line_1,
  input  wire logic              input_line_2,
  input  wire logic              input_line_3,
  input  wire logic              host_bus_select_n,
  output logic                   ready_out,
  // Bidirectional port
  input  wire logic [PORT_W-1:0] bidir_port_in,
  output logic      [PORT_W-1:0] bidir_port_out,
  output logic      [PORT_W-1:0] bidir_port_oe
);

  // ==========================================================
  // Helpers
  function automatic logic fell(input logic prev, input logic cur);
    fell = prev & ~cur;
  endfunction : fell

  logic [NIB_W-1:0]  feature_enable;
  logic [NIB_W-1:0]  shift_count_reg;
  logic              clock_gate_latch;
  logic [PORT_W-1:0] output_latch;
  logic              counter_mode_select;
  logic              interrupt_allow;
  logic              port_drive_allow;
  logic              serial_out_allow;

  assign counter_mode_select = feature_enable[FE_COUNTER];
  assign interrupt_allow     = feature_enable[FE_INT];
  assign port_drive_allow    = feature_enable[FE_DRIVE];
  assign serial_out_allow    = feature_enable[FE_SO];

  // ==========================================================
  // Pin synchronisers
  logic [12:0] pin_meta;
  logic [12:0] pin_sync;
  logic        si_s;
  logic        in1_s;
  logic        cs_n_s;
  logic        wr_n_s;
  logic        host_s;
  logic [PORT_W-1:0] port_s;
  logic        wr_prev;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pin_meta <= 13'h1FFF;
      pin_sync <= 13'h1FFF;
    end else begin
      pin_meta <= {serial_in, input_line_1, input_line_2, input_line_3,
                   host_bus_select_n, bidir_port_in};
      pin_sync <= pin_meta;
    end
  end

  assign si_s   = pin_sync[12];
  assign in1_s  = pin_sync[11];
  assign cs_n_s = pin_sync[10];
  assign wr_n_s = pin_sync[9];
  assign host_s = ~pin_sync[8];
  assign port_s = pin_sync[7:0];

  always_ff @(posedge clock or posedge reset) begin
    if (reset)
      wr_prev <= 1'b1;
    else
      wr_prev <= wr_n_s;
  end

  // Port levels always readable, drive or not
  assign port_read_data = port_s;

  // ==========================================================
  // Link domain: falls on serial_in for counter mode
  logic link_meta;
  logic link_sync;
  logic link_prev;
  logic link_toggle;

  always_ff @(posedge link_clock or posedge reset) begin
    if (reset) begin
      link_meta   <= 1'b1;
      link_sync   <= 1'b1;
      link_prev   <= 1'b1;
      link_toggle <= 1'b0;
    end else begin
      link_meta <= serial_in;
      link_sync <= link_meta;
      link_prev <= link_sync;
      // Relies on the source holding each low pulse long enough
      if (fell(link_prev, link_sync))
        link_toggle <= ~link_toggle;
    end
  end

  logic [2:0] tog_sync;
  logic       dec_event;

  always_ff @(posedge clock or posedge reset) begin
    if (reset)
      tog_sync <= 3'h0;
    else
      tog_sync <= {tog_sync[1:0], link_toggle};
  end

  assign dec_event = tog_sync[2] ^ tog_sync[1];

  // ==========================================================
  // Feature-enable register
  logic take;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      feature_enable <= FEATURE_RESET;
    end else begin
      if (load_feature_enable)
        feature_enable <= feature_value;
      else if (take)
        feature_enable[FE_INT] <= 1'b0;
    end
  end

  // ==========================================================
  // Shift / count register
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      shift_count_reg  <= NIB_RESET;
      accum_out        <= NIB_RESET;
      clock_gate_latch <= GATE_RESET;
    end else if (swap_accum_serial) begin
      shift_count_reg  <= accum_in;
      accum_out        <= shift_count_reg;
      clock_gate_latch <= carry_in;
    end else if (counter_mode_select) begin
      // 4-bit wrap from 0 to 15 is natural
      if (dec_event)
        shift_count_reg <= shift_count_reg - 4'h1;
    end else begin
      shift_count_reg <= {shift_count_reg[2:0], si_s};
    end
  end

  // Gated clock; only glitch-free while the gate changes on falling edges
  assign serial_clock_out = counter_mode_select ? clock_gate_latch
                                                : (clock_gate_latch & clock);
  assign serial_out = counter_mode_select ? serial_out_allow
                    : (serial_out_allow & shift_count_reg[3]);

  // ==========================================================
  // Interrupt qualification on input_line_1
  logic [1:0] low_count;
  logic       int_pending;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      low_count   <= 2'h0;
      int_pending <= 1'b0;
    end else begin
      if (in1_s)
        low_count <= 2'h0;
      else if (low_count != INT_LOW_MIN)
        low_count <= low_count + 2'h1;
      // Qualifying pulse: high-to-low then low two cycles; set wins over clear
      if (!host_s && !in1_s && low_count == (INT_LOW_MIN - 2'h1))
        int_pending <= 1'b1;
      else if (take)
        int_pending <= 1'b0;
    end
  end

  // Deferred while transfers or immediate loads keep chaining
  assign take = interrupt_allow && int_pending && instr_done && !instr_chain;
  assign interrupt_taken = take;

  // ==========================================================
  // Program counter and return stack
  logic [PC_W-1:0] stack_pc   [STACK_N];
  logic            stack_skip [STACK_N];
  logic [PC_W-1:0] pc_next_seq;
  logic            push;
  logic            pop;

  assign pc_next_seq = program_counter + PC_STEP;
  assign push = instr_done && (take || op_call);
  assign pop  = instr_done && !take && op_ret;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      program_counter <= PC_RESET;
    end else if (instr_done) begin
      if (take)
        program_counter <= INT_VECTOR;
      else if (op_ret)
        program_counter <= stack_pc[0];
      else if (op_call || op_jump)
        program_counter <= jump_addr;
      else
        program_counter <= pc_next_seq;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < STACK_N; i++) begin
        stack_pc[i]   <= PC_RESET;
        stack_skip[i] <= 1'b0;
      end
    end else if (push) begin
      // Bottom entry falls off when full
      stack_pc[0]   <= pc_next_seq;
      stack_skip[0] <= take & skip_pending;
      for (int i = 1; i < STACK_N; i++) begin
        stack_pc[i]   <= stack_pc[i-1];
        stack_skip[i] <= stack_skip[i-1];
      end
    end else if (pop) begin
      for (int i = 0; i < STACK_N - 1; i++) begin
        stack_pc[i]   <= stack_pc[i+1];
        stack_skip[i] <= stack_skip[i+1];
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset)
      skip_restore <= 1'b0;
    else
      skip_restore <= pop & stack_skip[0];
  end

  // ==========================================================
  // Output latch, port and host handshake
  logic host_write;
  logic host_read;

  assign host_write = host_s && !cs_n_s && fell(wr_prev, wr_n_s);
  assign host_read  = host_s && !cs_n_s && !in1_s;

  always_ff @(posedge clock or posedge reset) begin
    if (reset)
      output_latch <= PORT_RESET;
    else if (host_write)
      output_latch <= port_s;
    else if (load_latch)
      output_latch <= latch_value;
  end

  // Host write wins over a same-cycle program set
  always_ff @(posedge clock or posedge reset) begin
    if (reset)
      ready_out <= 1'b0;
    else if (host_write)
      ready_out <= 1'b0;
    else if (ready_set)
      ready_out <= 1'b1;
  end

  assign bidir_port_out = output_latch;
  assign bidir_port_oe  = {PORT_W{port_drive_allow | host_read}};

  // ==========================================================
  // Checks
  sequence host_write_seq;
    host_s && !cs_n_s && wr_prev && !wr_n_s;
  endsequence

  sequence int_take_seq;
    interrupt_allow && int_pending && instr_done && !instr_chain;
  endsequence

  shift_mode_a: assert property (@(posedge clock) disable iff (reset)
    !counter_mode_select && !swap_accum_serial
      |=> shift_count_reg == {$past(shift_count_reg[2:0]), $past(si_s)})
    else $error("shift register did not shift");
  counter_dec_a: assert property (@(posedge clock) disable iff (reset)
    counter_mode_select && dec_event && !swap_accum_serial && !load_feature_enable
      |=> shift_count_reg == $past(shift_count_reg) - 4'h1)
    else $error("counter did not decrement");
  swap_latch_a: assert property (@(posedge clock) disable iff (reset)
    swap_accum_serial |=> clock_gate_latch == $past(carry_in)
                          && accum_out == $past(shift_count_reg))
    else $error("swap did not exchange");
  so_gate_a: assert property (@(posedge clock) disable iff (reset)
    !counter_mode_select && !serial_out_allow |-> !serial_out)
    else $error("serial out not held low");
  int_clear_a: assert property (@(posedge clock) disable iff (reset)
    int_take_seq ##0 !load_feature_enable
      |=> !interrupt_allow && program_counter == INT_VECTOR)
    else $error("interrupt not taken properly");
  int_push_a: assert property (@(posedge clock) disable iff (reset)
    int_take_seq |=> stack_pc[0] == $past(program_counter) + PC_STEP)
    else $error("interrupt push wrong");

  port_drive_a: assert property (@(posedge clock) disable iff (reset)
    port_drive_allow |-> bidir_port_oe == 8'hFF && bidir_port_out == output_latch)
    else $error("port not driven from latch");

  host_write_a: assert property (@(posedge clock) disable iff (reset)
    host_write_seq |=> output_latch == $past(port_s) && !ready_out)
    else $error("host write not captured");

  ret_pop_a: assert property (@(posedge clock) disable iff (reset)
    pop |=> program_counter == $past(stack_pc[0]))
    else $error("return did not pop");

endmodule : serial_ctrl

`default_nettype wire

// ==== serial_partner.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Far side: peripheral, interrupt source, host
module serial_partner
  import serial_ctrl_pkg::*;
(
  // Clocks
  input  wire logic              clock,
  input  wire logic              link_clock,
  // Pins
  output logic                   serial_in,
  output logic                   input_line_1,
  output logic                   input_line_2,
  output logic                   input_line_3,
  output logic      [PORT_W-1:0] host_data
);
  initial begin
    serial_in    = 1'b1;
    input_line_1 = 1'b1;
    input_line_2 = 1'b1;
    input_line_3 = 1'b1;
    host_data    = 8'h5A;
  end
  task automatic si_level(input logic v);
    @(posedge link_clock);
    serial_in <= v;
  endtask : si_level
  // Low phase spans many instruction cycles
  task automatic si_pulse();
    si_level(1'b0);
    repeat (4) @(posedge link_clock);
    serial_in <= 1'b1;
  endtask : si_pulse
  task automatic int_pulse();
    @(posedge clock);
    input_line_1 <= 1'b0;
    repeat (4) @(posedge clock);
    input_line_1 <= 1'b1;
  endtask : int_pulse
  // Released data is inverted so stale bits never match
  task automatic host_write(input logic [PORT_W-1:0] d);
    @(posedge clock);
    host_data    <= d;
    input_line_2 <= 1'b0;
    repeat (2) @(posedge clock);
    input_line_3 <= 1'b0;
    repeat (5) @(posedge clock);
    input_line_3 <= 1'b1;
    repeat (2) @(posedge clock);
    input_line_2 <= 1'b1;
    host_data    <= ~d;
  endtask : host_write
  task automatic host_read(input logic on);
    @(posedge clock);
    input_line_2 <= ~on;
    input_line_1 <= ~on;
  endtask : host_read
endmodule : serial_partner
`default_nettype wire

// ==== enable_serial_io_interrupt_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module enable_serial_io_interrupt_tb_top
  import serial_ctrl_pkg::*;
;
  logic clock = 1'b0, reset = 1'b1, link_clock = 1'b0;
  logic instr_done = 1'b0, instr_chain = 1'b0, op_call = 1'b0, op_ret = 1'b0, op_jump = 1'b0;
  logic skip_pending = 1'b0, load_feature_enable = 1'b0, swap_accum_serial = 1'b0, carry_in = 1'b0;
  logic load_latch = 1'b0, ready_set = 1'b0, host_bus_select_n = 1'b1, took, sr;
  logic [PC_W-1:0]   jump_addr = 11'h000, pc_prev;
  logic [NIB_W-1:0]  feature_value = 4'h0, accum_in = 4'h0, accum_out;
  logic [PORT_W-1:0] latch_value = 8'h00, port_read_data, bidir_port_out, bidir_port_oe, host_data;
  logic [PC_W-1:0]   program_counter;
  logic skip_restore, interrupt_taken, serial_in, serial_out, serial_clock_out;
  logic input_line_1, input_line_2, input_line_3, ready_out;
  wire logic [PORT_W-1:0] bidir_port_in;
  int errors = 0;
  int checks = 0;

  always #5 clock = ~clock;
  initial begin
    #7;
    forever #24 link_clock = ~link_clock;
  end
  // Undriven port bits follow the far side
  assign bidir_port_in = (bidir_port_out & bidir_port_oe) | (host_data & ~bidir_port_oe);

  serial_ctrl DUT (.clock, .reset, .link_clock, .instr_done, .instr_chain, .op_call, .op_ret,
    .op_jump, .jump_addr, .skip_pending, .skip_restore, .load_feature_enable, .feature_value,
    .swap_accum_serial, .accum_in, .carry_in, .accum_out, .load_latch, .latch_value, .ready_set,
    .port_read_data, .program_counter, .interrupt_taken, .serial_in, .serial_out,
    .serial_clock_out, .input_line_1, .input_line_2, .input_line_3, .host_bus_select_n,
    .ready_out, .bidir_port_in, .bidir_port_out, .bidir_port_oe);
  serial_partner partner (.clock, .link_clock, .serial_in, .input_line_1, .input_line_2,
    .input_line_3, .host_data);

  // ==========================================
  // Bench tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc
  // One instruction; pc_prev is the count at the taking edge
  task automatic op(input logic [3:0] k, input logic [PC_W-1:0] a);
    @(posedge clock);
    {instr_chain, op_jump, op_ret, op_call} <= k;
    jump_addr <= a;
    instr_done <= 1'b1;
    #1;
    pc_prev = program_counter;
    took = interrupt_taken;
    @(posedge clock);
    instr_done <= 1'b0;
    {instr_chain, op_jump, op_ret, op_call} <= 4'h0;
    skip_pending <= 1'b0;
    #1;
  endtask : op
  task automatic feat(input logic [NIB_W-1:0] v);
    @(posedge clock);
    load_feature_enable <= 1'b1;
    feature_value <= v;
    cyc(1);
    load_feature_enable <= 1'b0;
  endtask : feat
  task automatic swap(input logic [NIB_W-1:0] a, input logic c);
    @(posedge clock);
    swap_accum_serial <= 1'b1;
    accum_in <= a;
    carry_in <= c;
    cyc(1);
    swap_accum_serial <= 1'b0;
  endtask : swap
  task automatic sk_check(input logic [1:0] e);
    @(posedge clock);
    #2;
    check(serial_clock_out, e[1], "clock out high");
    @(negedge clock);
    #2;
    check(serial_clock_out, e[0], "clock out low");
  endtask : sk_check
  task automatic counted(input logic [NIB_W-1:0] start, input logic [NIB_W-1:0] exp);
    swap(start, 1'b0);
    partner.si_pulse();
    cyc(8);
    swap(4'h0, 1'b1);
    check(accum_out, exp, "count");
  endtask : counted

  // About ten times the expected run
  initial begin
    #20000;
    errors++;
    summarize();
  end

  // ==========================================
  // Tests
  initial begin
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    cyc(1);
    check(program_counter, PC_RESET, "pc reset");
    check({ready_out, serial_out, bidir_port_oe}, 10'h000, "outputs reset");
    sk_check(2'b10);
    cyc(6);
    swap(4'h0, 1'b0);
    check(accum_out, 4'hF, "shift in ones");
    sk_check(2'b00);
    cyc(4);
    check(serial_out, 1'b0, "out blocked");
    partner.si_level(1'b0);
    feat(4'h8);
    cyc(4);
    swap(4'h1, 1'b1);
    cyc(3);
    check(serial_out, 1'b1, "msb out");
    cyc(1);
    check(serial_out, 1'b0, "msb gone");
    sk_check(2'b10);
    $display("test shift done");
    partner.si_level(1'b1);
    feat(4'h9);
    swap(4'h0, 1'b0);
    check(serial_out, 1'b1, "count out");
    sk_check(2'b00);
    counted(4'h5, 4'h4);
    counted(4'h0, 4'hF);
    sk_check(2'b11);
    $display("test counter done");
    feat(4'h4);
    @(posedge clock);
    load_latch <= 1'b1;
    latch_value <= 8'hA5;
    cyc(1);
    load_latch <= 1'b0;
    check({bidir_port_oe, bidir_port_out}, 16'hFFA5, "port drive");
    cyc(3);
    check(port_read_data, 8'hA5, "port read driven");
    feat(4'h0);
    cyc(3);
    check({bidir_port_oe, port_read_data}, 16'h005A, "port input");
    $display("test port done");
    feat(4'h2);
    op(4'h4, 11'h123);
    check(program_counter, 11'h123, "jump");
    op(4'h0, 11'h000);
    check(program_counter, 11'h124, "step");
    partner.int_pulse();
    cyc(3);
    skip_pending <= 1'b1;
    op(4'h0, 11'h000);
    check(pc_prev, 11'h124, "pc before take");
    check({took, program_counter}, {1'b1, INT_VECTOR}, "vector");
    op(4'h2, 11'h000);
    sr = skip_restore;
    check(program_counter, 11'h125, "return");
    cyc(1);
    check({sr, skip_restore}, 2'b10, "skip restore");
    partner.int_pulse();
    cyc(4);
    op(4'h0, 11'h000);
    check(took, 1'b0, "allow cleared");
    feat(4'h2);
    op(4'h8, 11'h000);
    check(took, 1'b0, "chain defers");
    op(4'h0, 11'h000);
    check({took, program_counter}, {1'b1, INT_VECTOR}, "late take");
    $display("test interrupt done");
    for (int i = 1; i <= 4; i++)
      op(4'h1, 11'(i * 256));
    for (int i = 3; i >= 1; i--) begin
      op(4'h2, 11'h000);
      check(program_counter, 11'(i * 256 + 1), "pop");
    end
    $display("test stack done");
    @(posedge clock);
    host_bus_select_n <= 1'b0;
    ready_set <= 1'b1;
    cyc(1);
    ready_set <= 1'b0;
    cyc(3);
    check(ready_out, 1'b1, "ready set");
    partner.host_write(8'h3C);
    cyc(2);
    check({ready_out, bidir_port_out}, 9'h03C, "host write");
    partner.host_read(1'b1);
    cyc(4);
    check(bidir_port_oe, 8'hFF, "host read");
    partner.host_read(1'b0);
    cyc(4);
    check(bidir_port_oe, 8'h00, "host idle");
    $display("test host done");
    summarize();
  end
endmodule : enable_serial_io_interrupt_tb_top
`default_nettype wire
